// ===== design/timer8_pkg.sv
// Shared constants and carrier types for the 8-bit compare timer
package timer8_pkg;
    localparam logic [7:0] ADDR_CTRL_A    = 8'h00;
    localparam logic [7:0] ADDR_CTRL_B    = 8'h04;
    localparam logic [7:0] ADDR_COUNT     = 8'h08;
    localparam logic [7:0] ADDR_CMP_A     = 8'h0C;
    localparam logic [7:0] ADDR_CMP_B     = 8'h10;
    localparam logic [7:0] ADDR_IRQ_MASK  = 8'h14;
    localparam logic [7:0] ADDR_IRQ_FLAG  = 8'h18;
    localparam logic [7:0] ADDR_ASYNC     = 8'h1C;
    localparam logic [7:0] ADDR_POWER     = 8'h20;
    // Control A: action A [7:6], action B [5:4], mode bits 1..0 [1:0]
    localparam int COM_A_POS   = 6;
    localparam int COM_B_POS   = 4;
    // Control B: force A [7], force B [6], mode bit 2 [3], clock [2:0]
    localparam int FORCE_A_POS = 7;
    localparam int FORCE_B_POS = 6;
    localparam int WGM2_POS    = 3;
    // Flag and mask bits, then the async-select and power-reduce bit positions
    localparam int OVF_POS     = 0;
    localparam int MATCH_A_POS = 1;
    localparam int MATCH_B_POS = 2;
    localparam int ASYNC_POS   = 3;
    localparam int POWER_POS   = 0;
    localparam logic [7:0] RESET_BYTE = 8'h00;
    localparam logic [7:0] BOTTOM_VAL = 8'h00;
    localparam logic [7:0] MAX_VAL    = 8'hFF;
    localparam logic [2:0] CS_STOP    = 3'h0;
    localparam logic [1:0] COM_NONE   = 2'h0;
    localparam logic [1:0] COM_TOGGLE = 2'h1;
    localparam logic [1:0] COM_CLEAR  = 2'h2;
    localparam logic [1:0] COM_SET    = 2'h3;

    typedef enum logic [2:0] {
        WGM_NORMAL   = 3'b000,
        WGM_PC_MAX   = 3'b001,
        WGM_CTC      = 3'b010,
        WGM_FAST_MAX = 3'b011,
        WGM_RSVD4    = 3'b100,
        WGM_PC_CMP   = 3'b101,
        WGM_RSVD6    = 3'b110,
        WGM_FAST_CMP = 3'b111
    } wgm_e;

    typedef struct packed {
        logic        cyc;
        logic        stb;
        logic        we;
        logic [7:0]  adr;
        logic [3:0]  sel;
        logic [31:0] dat;
    } wb_req_s;
endpackage

// ===== design/timer8_compare.sv
// 8-bit up/down timer with two compare channels behind a Wishbone slave
//
// Added by the designer: the register offsets and register access over Wishbone.
`timescale 1ns/1ps
module timer8_compare
    import timer8_pkg::*;
(
    input  wire logic        i_ref_clk,
    input  wire logic        i_resetn,
    input  wire wb_req_s     i_wb_req,
    output logic [31:0]      o_wb_dat,
    output logic             o_wb_ack,
    input  wire logic        i_osc_pin_in,
    output logic             o_osc_pin_out,
    input  wire logic [2:0]  i_irq_served,
    output logic [2:0]       o_irq_req,
    output logic             o_wave_out_a,
    output logic             o_wave_out_b
);
    logic [7:0] ctrl_a_reg;
    logic [7:0] ctrl_b_reg;
    logic [7:0] count_value_reg;
    logic [7:0] compare_value_a_reg;
    logic [7:0] compare_value_b_reg;
    logic [7:0] buf_a_reg;
    logic [7:0] buf_b_reg;
    logic [2:0] irq_mask_reg;
    logic [2:0] irq_flag_reg;
    logic       async_clock_select_reg;
    logic       power_reduce_timer_reg;
    logic       osc_prev_reg;
    logic [9:0] presc_reg;
    logic       down_reg;
    logic       block_reg;
    logic       wave_a_reg;
    logic       wave_b_reg;
    logic       ack_reg;
    logic [31:0] rdat_reg;
    wire logic       wb_req    = i_wb_req.cyc & i_wb_req.stb;
    wire logic       wr_fire   = wb_req & i_wb_req.we & ack_reg & i_wb_req.sel[0];
    wire logic [7:0] wdat      = i_wb_req.dat[7:0];
    wire logic       wr_ctrl_a = wr_fire & (i_wb_req.adr == ADDR_CTRL_A);
    wire logic       wr_ctrl_b = wr_fire & (i_wb_req.adr == ADDR_CTRL_B);
    wire logic       wr_count  = wr_fire & (i_wb_req.adr == ADDR_COUNT);
    wire logic       wr_cmp_a  = wr_fire & (i_wb_req.adr == ADDR_CMP_A);
    wire logic       wr_cmp_b  = wr_fire & (i_wb_req.adr == ADDR_CMP_B);
    wire logic       wr_flag   = wr_fire & (i_wb_req.adr == ADDR_IRQ_FLAG);

    wire wgm_e       mode      = wgm_e'({ctrl_b_reg[WGM2_POS], ctrl_a_reg[1:0]});
    wire logic [2:0] clock_select_field = ctrl_b_reg[2:0];
    wire logic [1:0] com_a     = ctrl_a_reg[COM_A_POS +: 2];
    wire logic [1:0] com_b     = ctrl_a_reg[COM_B_POS +: 2];
    wire logic is_fast    = (mode == WGM_FAST_MAX) || (mode == WGM_FAST_CMP);
    wire logic is_pc      = (mode == WGM_PC_MAX) || (mode == WGM_PC_CMP);
    wire logic top_is_cmp = (mode == WGM_CTC) || (mode == WGM_PC_CMP) || (mode == WGM_FAST_CMP);
    wire logic is_pwm     = is_fast | is_pc;
    // Extreme-value detectors
    wire logic at_bottom = (count_value_reg == BOTTOM_VAL);
    wire logic at_max    = (count_value_reg == MAX_VAL);
    wire logic [7:0] top_val = top_is_cmp ? compare_value_a_reg : MAX_VAL;
    wire logic at_top    = (count_value_reg == top_val);
    // Tick source: the oscillator pin is sampled, so it must run well below the I/O clock
    wire logic osc_rise = i_osc_pin_in & ~osc_prev_reg;
    wire logic src_pulse = async_clock_select_reg ? osc_rise : 1'b1;
    logic tap;
    always_comb begin
        case (clock_select_field)
            3'h1:    tap = 1'b1;
            3'h2:    tap = &presc_reg[2:0];
            3'h3:    tap = &presc_reg[4:0];
            3'h4:    tap = &presc_reg[5:0];
            3'h5:    tap = &presc_reg[6:0];
            3'h6:    tap = &presc_reg[7:0];
            3'h7:    tap = &presc_reg[9:0];
            default: tap = 1'b0;
        endcase
    end
    // Gated off while stopped or while the module is powered down
    wire logic timer_tick = src_pulse & tap & (clock_select_field != CS_STOP)
                          & ~power_reduce_timer_reg;
    wire logic match_a = (count_value_reg == compare_value_a_reg) & ~block_reg;
    wire logic match_b = (count_value_reg == compare_value_b_reg) & ~block_reg;
    // Osc out is the inverting amplifier leg of the crystal pair
    always_ff @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            osc_prev_reg  <= 1'b0;
            o_osc_pin_out <= 1'b0;
            presc_reg     <= 10'h000;
        end else begin
            osc_prev_reg  <= i_osc_pin_in;
            o_osc_pin_out <= ~i_osc_pin_in;
            if (src_pulse) begin
                presc_reg <= presc_reg + 10'h001;
            end
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            ctrl_a_reg             <= RESET_BYTE;
            ctrl_b_reg             <= RESET_BYTE;
            irq_mask_reg           <= 3'h0;
            async_clock_select_reg <= 1'b0;
            power_reduce_timer_reg <= 1'b0;
        end else begin
            if (wr_ctrl_a) begin
                ctrl_a_reg <= wdat;
            end
            // Force bits are strobes and never stored
            if (wr_ctrl_b) begin
                ctrl_b_reg <= {2'b00, wdat[5:0]};
            end
            if (wr_fire && i_wb_req.adr == ADDR_IRQ_MASK) begin
                irq_mask_reg <= wdat[2:0];
            end
            if (wr_fire && i_wb_req.adr == ADDR_ASYNC) begin
                async_clock_select_reg <= wdat[ASYNC_POS];
            end
            if (wr_fire && i_wb_req.adr == ADDR_POWER) begin
                power_reduce_timer_reg <= wdat[POWER_POS];
            end
        end
    end

    // Counter unit
    always_ff @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            count_value_reg <= RESET_BYTE;
            down_reg        <= 1'b0;
        end else if (wr_count) begin
            count_value_reg <= wdat;
        end else if (timer_tick) begin
            if (is_pc) begin
                if (!down_reg && at_top) begin
                    down_reg        <= 1'b1;
                    count_value_reg <= count_value_reg - 8'h01;
                end else if (down_reg && at_bottom) begin
                    down_reg        <= 1'b0;
                    count_value_reg <= count_value_reg + 8'h01;
                end else if (down_reg) begin
                    count_value_reg <= count_value_reg - 8'h01;
                end else begin
                    count_value_reg <= count_value_reg + 8'h01;
                end
            end else begin
                down_reg <= 1'b0;
                if ((is_fast || mode == WGM_CTC) && at_top) begin
                    count_value_reg <= BOTTOM_VAL;
                end else begin
                    count_value_reg <= count_value_reg + 8'h01;
                end
            end
        end
    end

    // Cleared by the next tick, so a write while stopped still blocks one match
    always_ff @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            block_reg <= 1'b0;
        end else if (wr_count) begin
            block_reg <= 1'b1;
        end else if (timer_tick) begin
            block_reg <= 1'b0;
        end
    end

    // Compare registers and their PWM buffers
    wire logic buf_load = timer_tick & is_pwm & (is_fast ? at_bottom : at_top);
    always_ff @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            compare_value_a_reg <= RESET_BYTE;
            compare_value_b_reg <= RESET_BYTE;
            buf_a_reg           <= RESET_BYTE;
            buf_b_reg           <= RESET_BYTE;
        end else begin
            if (wr_cmp_a) begin
                buf_a_reg <= wdat;
            end
            if (wr_cmp_b) begin
                buf_b_reg <= wdat;
            end
            if (wr_cmp_a && !is_pwm) begin
                compare_value_a_reg <= wdat;
            end else if (buf_load) begin
                compare_value_a_reg <= buf_a_reg;
            end
            if (wr_cmp_b && !is_pwm) begin
                compare_value_b_reg <= wdat;
            end else if (buf_load) begin
                compare_value_b_reg <= buf_b_reg;
            end
        end
    end

    // Overflow event per mode
    logic ovf_evt;
    always_comb begin
        if (is_pc) begin
            ovf_evt = down_reg & at_bottom;
        end else if (is_fast) begin
            ovf_evt = at_top;
        end else begin
            ovf_evt = at_max;
        end
    end

    logic [2:0] set_vec;
    always_comb begin
        set_vec              = 3'h0;
        set_vec[OVF_POS]     = timer_tick & ~wr_count & ovf_evt;
        set_vec[MATCH_A_POS] = timer_tick & match_a;
        set_vec[MATCH_B_POS] = timer_tick & match_b;
    end

    // Set wins over a same-cycle clear from software or service
    always_ff @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            irq_flag_reg <= 3'h0;
        end else begin
            irq_flag_reg <= set_vec | (irq_flag_reg & ~i_irq_served
                          & ~(wr_flag ? wdat[2:0] : 3'h0));
        end
    end
    assign o_irq_req = irq_flag_reg & irq_mask_reg;
    // Waveform generator
    wire logic force_a = wr_ctrl_b & wdat[FORCE_A_POS] & ~is_pwm;
    wire logic force_b = wr_ctrl_b & wdat[FORCE_B_POS] & ~is_pwm;

    function automatic logic wave_next(input logic cur, input logic [1:0] com,
                                       input logic hit, input logic frc,
                                       input logic fast, input logic pc,
                                       input logic tick, input logic bot,
                                       input logic dn);
        logic v;
        v = cur;
        if (com == COM_NONE) begin
            v = cur;
        end else if (fast) begin
            if (tick && hit) begin
                v = (com == COM_SET);
            end else if (tick && bot) begin
                v = (com != COM_SET);
            end
        end else if (pc) begin
            if (tick && hit) begin
                v = (com == COM_SET) ? ~dn : dn;
            end
        end else if ((tick && hit) || frc) begin
            case (com)
                COM_TOGGLE: v = ~cur;
                COM_CLEAR:  v = 1'b0;
                COM_SET:    v = 1'b1;
                default:    v = cur;
            endcase
        end
        return v;
    endfunction

    always_ff @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            wave_a_reg <= 1'b0;
            wave_b_reg <= 1'b0;
        end else begin
            wave_a_reg <= wave_next(wave_a_reg, com_a, match_a, force_a, is_fast, is_pc,
                                    timer_tick, at_bottom, down_reg);
            wave_b_reg <= wave_next(wave_b_reg, com_b, match_b, force_b, is_fast, is_pc,
                                    timer_tick, at_bottom, down_reg);
        end
    end
    assign o_wave_out_a = wave_a_reg;
    assign o_wave_out_b = wave_b_reg;

    // Wishbone slave: one wait state, unmapped reads return zero
    logic [7:0] rsel;
    always_comb begin
        case (i_wb_req.adr)
            ADDR_CTRL_A:   rsel = ctrl_a_reg;
            ADDR_CTRL_B:   rsel = ctrl_b_reg;
            ADDR_COUNT:    rsel = count_value_reg;
            ADDR_CMP_A:    rsel = is_pwm ? buf_a_reg : compare_value_a_reg;
            ADDR_CMP_B:    rsel = is_pwm ? buf_b_reg : compare_value_b_reg;
            ADDR_IRQ_MASK: rsel = {5'h00, irq_mask_reg};
            ADDR_IRQ_FLAG: rsel = {5'h00, irq_flag_reg};
            ADDR_ASYNC:    rsel = {4'h0, async_clock_select_reg, 3'h0};
            ADDR_POWER:    rsel = {7'h00, power_reduce_timer_reg};
            default:       rsel = 8'h00;
        endcase
    end

    always_ff @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            ack_reg  <= 1'b0;
            rdat_reg <= 32'h0000_0000;
        end else begin
            ack_reg <= wb_req & ~ack_reg;
            if (wb_req && !ack_reg) begin
                rdat_reg <= {24'h00_0000, rsel};
            end
        end
    end
    assign o_wb_ack = ack_reg;
    assign o_wb_dat = rdat_reg;
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_resetn);

    chk_stop_holds: assert property (
        (clock_select_field == CS_STOP && !wr_count) |=> $stable(count_value_reg))
        else $error("counter moved while stopped");
    chk_write_wins: assert property (
        wr_count |=> count_value_reg == $past(wdat))
        else $error("counter write lost");
    chk_match_flag: assert property (
        (timer_tick && count_value_reg == compare_value_a_reg && !block_reg)
        |=> irq_flag_reg[MATCH_A_POS])
        else $error("match A flag not set");
    chk_block_match: assert property (
        (block_reg && timer_tick && !irq_flag_reg[MATCH_A_POS]) |=> !irq_flag_reg[MATCH_A_POS])
        else $error("match not blocked after counter write");
    chk_irq_gate: assert property (
        (timer_tick && match_a && irq_mask_reg[MATCH_A_POS] && !wr_fire)
        |=> o_irq_req[MATCH_A_POS])
        else $error("match A request not raised");
    chk_normal_wrap: assert property (
        (mode == WGM_NORMAL && timer_tick && at_max && !wr_count)
        |=> count_value_reg == BOTTOM_VAL && irq_flag_reg[OVF_POS])
        else $error("normal wrap or overflow wrong");
    chk_ctc_clear: assert property (
        (mode == WGM_CTC && timer_tick && at_top && !wr_count)
        |=> count_value_reg == BOTTOM_VAL)
        else $error("clear on compare A missed");
    chk_power_off: assert property (
        (power_reduce_timer_reg && !wr_count) |=> $stable(count_value_reg))
        else $error("counter moved while powered down");
    chk_force_noflag: assert property (
        (force_a && !timer_tick && !irq_flag_reg[MATCH_A_POS]) |=> !irq_flag_reg[MATCH_A_POS])
        else $error("force set the match flag");
    chk_pwm_buffer: assert property (
        (wr_cmp_b && is_pwm && !buf_load) |=> $stable(compare_value_b_reg))
        else $error("PWM compare written directly");
    chk_ack_pulse: assert property (
        o_wb_ack |=> !o_wb_ack)
        else $error("ack held two cycles");
endmodule

// ===== test/testbench.sv
// Self-checking testbench for the 8-bit compare timer
`timescale 1ns/1ps
`define CHK(got, exp) begin \
    compares++; \
    if ((got) !== (exp)) begin \
        err_total++; \
        $display("mismatch at %0t: got %h expected %h", $time, (got), (exp)); \
    end \
end
module testbench import timer8_pkg::*;;
    logic        ref_clk;
    logic        resetn;
    wb_req_s     wb_req;
    logic [31:0] wb_dat;
    logic        wb_ack;
    logic        osc_in;
    logic        osc_out;
    logic [2:0]  irq_served;
    logic [2:0]  irq_req;
    logic        wave_a;
    logic        wave_b;
    int          err_total;
    int          compares;

    timer8_compare dut_u (
        .i_ref_clk     (ref_clk),
        .i_resetn      (resetn),
        .i_wb_req      (wb_req),
        .o_wb_dat      (wb_dat),
        .o_wb_ack      (wb_ack),
        .i_osc_pin_in  (osc_in),
        .o_osc_pin_out (osc_out),
        .i_irq_served  (irq_served),
        .o_irq_req     (irq_req),
        .o_wave_out_a  (wave_a),
        .o_wave_out_b  (wave_b)
    );

    always #50 ref_clk = ~ref_clk;

    task automatic tally_and_finish();
        $display("mismatches %0d, comparisons %0d", err_total, compares);
        if (err_total == 0 && compares > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // Entered just after a rising edge; ack and read data are taken at the edge that sees ack
    task automatic bus(input logic we, input logic [7:0] adr, input logic [7:0] wd,
                       output logic [7:0] rd);
        int n;
        wb_req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: adr, sel: 4'hF,
                    dat: {24'h00_0000, wd}};
        n = 0;
        do begin
            @(posedge ref_clk);
            n++;
        end while (wb_ack !== 1'b1 && n < 16);
        if (n >= 16) begin
            err_total++;
            tally_and_finish();
        end
        rd = wb_dat[7:0];
        `CHK(wb_dat[31:8], 24'h00_0000)
        wb_req <= '0;
        @(posedge ref_clk);
    endtask

    task automatic wr(input logic [7:0] adr, input logic [7:0] d);
        logic [7:0] x;
        bus(1'b1, adr, d, x);
    endtask

    task automatic rd_chk(input logic [7:0] adr, input logic [7:0] exp);
        logic [7:0] x;
        bus(1'b0, adr, 8'h00, x);
        `CHK(x, exp)
    endtask

    // Oscillator pulses slow enough for the pin sampler to see every edge
    task automatic osc(input int n);
        repeat (n) begin
            osc_in <= 1'b1;
            repeat (3) @(posedge ref_clk);
            osc_in <= 1'b0;
            repeat (3) @(posedge ref_clk);
        end
        repeat (4) @(posedge ref_clk);
    endtask

    task automatic t_reset();
        logic [7:0] regs [6] = '{ADDR_COUNT, ADDR_CMP_A, ADDR_CMP_B, ADDR_IRQ_MASK,
                                 ADDR_IRQ_FLAG, ADDR_CTRL_B};
        foreach (regs[i]) rd_chk(regs[i], 8'h00);
        wr(8'h24, 8'h5A);
        rd_chk(8'h24, 8'h00);
    endtask

    task automatic t_stop();
        wr(ADDR_ASYNC, 8'h08);
        wr(ADDR_COUNT, 8'h10);
        osc(3);
        rd_chk(ADDR_COUNT, 8'h10);
        `CHK(osc_out, ~osc_in)
    endtask

    task automatic t_normal();
        wr(ADDR_CTRL_A, 8'h00);
        wr(ADDR_COUNT, 8'hFE);
        wr(ADDR_CTRL_B, 8'h01);
        osc(1);
        rd_chk(ADDR_COUNT, 8'hFF);
        rd_chk(ADDR_IRQ_FLAG, 8'h00);
        osc(1);
        rd_chk(ADDR_COUNT, 8'h00);
        rd_chk(ADDR_IRQ_FLAG, 8'h01);
        `CHK(irq_req, 3'b000)
        wr(ADDR_IRQ_MASK, 8'h01);
        `CHK(irq_req, 3'b001)
        irq_served <= 3'b001;
        @(posedge ref_clk);
        irq_served <= 3'b000;
        @(posedge ref_clk);
        rd_chk(ADDR_IRQ_FLAG, 8'h00);
        `CHK(irq_req, 3'b000)
    endtask

    task automatic t_match();
        logic w;
        w = wave_a;
        wr(ADDR_IRQ_MASK, 8'h06);
        wr(ADDR_CMP_A, 8'h05);
        wr(ADDR_CMP_B, 8'h06);
        wr(ADDR_COUNT, 8'h03);
        osc(2);
        rd_chk(ADDR_COUNT, 8'h05);
        rd_chk(ADDR_IRQ_FLAG, 8'h00);
        osc(1);
        rd_chk(ADDR_IRQ_FLAG, 8'h02);
        `CHK(irq_req, 3'b010)
        osc(1);
        rd_chk(ADDR_IRQ_FLAG, 8'h06);
        `CHK(wave_a, w)
        wr(ADDR_IRQ_FLAG, 8'h02);
        rd_chk(ADDR_IRQ_FLAG, 8'h04);
        wr(ADDR_IRQ_FLAG, 8'h04);
        // Writing the compare value itself: that match must be swallowed
        wr(ADDR_COUNT, 8'h05);
        osc(1);
        rd_chk(ADDR_COUNT, 8'h06);
        rd_chk(ADDR_IRQ_FLAG, 8'h00);
    endtask

    task automatic t_ctc();
        logic w;
        wr(ADDR_CTRL_A, 8'h42);
        wr(ADDR_CMP_A, 8'h03);
        wr(ADDR_COUNT, 8'h00);
        wr(ADDR_IRQ_FLAG, 8'h07);
        w = wave_a;
        osc(3);
        rd_chk(ADDR_COUNT, 8'h03);
        `CHK(wave_a, w)
        osc(1);
        rd_chk(ADDR_COUNT, 8'h00);
        rd_chk(ADDR_IRQ_FLAG, 8'h02);
        `CHK(wave_a, ~w)
    endtask

    task automatic t_force();
        logic [1:0] codes [5] = '{COM_SET, COM_TOGGLE, COM_NONE, COM_CLEAR, COM_TOGGLE};
        logic       e;
        e = 1'b0;
        wr(ADDR_CTRL_B, 8'h00);
        wr(ADDR_IRQ_FLAG, 8'h07);
        foreach (codes[i]) begin
            wr(ADDR_CTRL_A, {codes[i], codes[i], 4'h0});
            wr(ADDR_CTRL_B, 8'hC0);
            case (codes[i])
                COM_SET: e = 1'b1;
                COM_CLEAR: e = 1'b0;
                COM_TOGGLE: e = ~e;
                default: e = e;
            endcase
            `CHK({wave_a, wave_b}, {e, e})
        end
        rd_chk(ADDR_CTRL_B, 8'h00);
        rd_chk(ADDR_IRQ_FLAG, 8'h00);
    endtask

    // Old compare B must stay active while the new value sits in the buffer
    task automatic t_buffer();
        wr(ADDR_CTRL_A, 8'h00);
        wr(ADDR_CMP_B, 8'h02);
        wr(ADDR_CTRL_A, 8'h03);
        wr(ADDR_CMP_B, 8'h80);
        rd_chk(ADDR_CMP_B, 8'h80);
        wr(ADDR_COUNT, 8'h01);
        wr(ADDR_IRQ_FLAG, 8'h07);
        wr(ADDR_CTRL_B, 8'h01);
        osc(2);
        rd_chk(ADDR_COUNT, 8'h03);
        rd_chk(ADDR_IRQ_FLAG, 8'h04);
    endtask

    // Clock runs from the ack edge of one write to the ack edge of the next: three ticks
    task automatic t_iosrc();
        wr(ADDR_CTRL_A, 8'h00);
        wr(ADDR_CTRL_B, 8'h00);
        wr(ADDR_ASYNC, 8'h00);
        wr(ADDR_POWER, 8'h01);
        wr(ADDR_COUNT, 8'h00);
        wr(ADDR_CTRL_B, 8'h01);
        wr(ADDR_CTRL_B, 8'h00);
        rd_chk(ADDR_COUNT, 8'h00);
        wr(ADDR_POWER, 8'h00);
        wr(ADDR_CTRL_B, 8'h01);
        wr(ADDR_CTRL_B, 8'h00);
        rd_chk(ADDR_COUNT, 8'h03);
    endtask

    initial begin
        repeat (20000) @(posedge ref_clk);
        err_total++;
        tally_and_finish();
    end

    initial begin
        ref_clk = 1'b0;
        resetn = 1'b0;
        wb_req = '0;
        osc_in = 1'b0;
        irq_served = 3'b000;
        err_total = 0;
        compares = 0;
        repeat (5) @(posedge ref_clk);
        `CHK(irq_req, 3'b000)
        resetn <= 1'b1;
        @(posedge ref_clk);
        t_reset();
        t_stop();
        t_normal();
        t_match();
        t_ctc();
        t_force();
        t_buffer();
        t_iosrc();
        tally_and_finish();
    end
endmodule
